// *** logic/hsr_ctrl.sv ***
// Purpose: Role control of one unit of a hot-standby bridge pair.
// Assumes: Health and peer inputs come from other logic on clk.
// Notes: Registers are reached through a simple request port.
//
// Function
// RL1: Standby takes leader identity on changeover.
// RL2: Configuration writable only while leader; the code also leaves it writable whenever redundant pair mode is off.
// RL3: Standby fetches whole configuration on mismatch.
// RL4: Peer link is full-duplex point-to-point.
// RL5: Standby identity equals leader plus one.
// RL6: Commit propagates; commits blocked during fetch.
// RL7: Takeover waits roughly sixteen seconds restart.
// RL8: Programming connections close at takeover.
// RL9: Broadcast words reserved in redundant mode.
// RL10: Leader switches over when sole station.
// RL11: Leader switches when all Ethernet links lost.
// RL12: Standby leads when broadcast and link lost.
// RL13: Firmware update completion triggers switchover.
// RL14: Older firmware unit becomes leader.
// RL15: Writing swap key requests role swap.
// RL16: Role swap exchanges roles in working pair.
// RL17: Swap ignored unless standby ready.
// RL18: Own-state register reports state code.
// RL19: Peer-state register, 255 when unknown.
// RL20: Serial number as low and high words.
// RL21: Five broadcast words published by each unit.
// RL22: Leader init enters redundant mode.
// RL23: Standby reboots after configuration fetch.
// RL24: State registers track every transition.
`timescale 1ns/1ps
`include "hsr_defines.svh"
module hsr_ctrl #(
    parameter int unsigned RESTART_CYC = `HSR_RESTART_CYC,
    parameter int unsigned SECOND_CYC = `HSR_SECOND_CYC,
    parameter logic [31:0] SERIAL_NUMBER = 32'h0000_0001, // Arbitrary value.
    parameter int unsigned ETH_PORTS = 2
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire hsr_pkg::hsr_reg_req_t regReq,
    output hsr_pkg::hsr_bcast_t bcastWords,
    output logic [15:0] regRdData,
    output logic regRdValid,
    input wire logic initLeaderCmd,
    input wire logic initStandbyCmd,
    input wire logic soleStation,
    input wire logic [ETH_PORTS-1:0] ethLink,
    input wire logic peerBcastSeen,
    input wire logic peerLinkUp,
    input wire logic peerValid,
    input wire logic [3:0] peerState,
    input wire logic peerConfigDiffers,
    input wire logic fetchDone,
    input wire logic firmwareUpdateDone,
    input wire logic peerFirmwareNewer,
    input wire logic peerFirmwareOlder,
    input wire logic commitRequest,
    input wire logic [31:0] ipBase,
    input wire logic [7:0] nodeBase,
    output logic redundantPairMode,
    output logic configWritable,
    output logic firmwareUpdateAllowed,
    output logic fetchConfig,
    output logic commitConfiguration,
    output logic closeProgramming,
    output logic rebootRequest,
    output logic [31:0] ipAddress,
    output logic [7:0] nodeNumber,
    output logic mailboxBcastAllowed
);
    import hsr_pkg::*;

    // ==================================================================
    // State record
    // ==================================================================
    typedef struct packed {
        hsr_state_t st;
        logic pairMode;
        logic [31:0] restartCnt;
        logic [31:0] secCnt;
        logic [15:0] aliveCnt;
        logic [15:0] rdData;
        logic rdValid;
        logic commit;
        logic closeProg;
        logic reboot;
        logic swapPending;
    } hsr_core_t;

    hsr_core_t cur;
    hsr_core_t next_cur;
    logic allLinksLost;
    logic standbyReady;
    logic swapWrite;

    // Decode of register reads, shared by the read port.
    function automatic logic [15:0] readReg(input logic [15:0] a, input hsr_state_t s,
                                            input logic pv, input logic [3:0] ps);
        logic [15:0] r;
        r = 16'h0000;
        unique case (a)
            `HSR_OFF_OWN_STATE: r = {12'h000, s}; // RL18
            `HSR_OFF_PEER_STATE: r = pv ? {12'h000, ps} : `HSR_PEER_UNKNOWN; // RL19
            `HSR_OFF_SERIAL_LOW: r = SERIAL_NUMBER[15:0]; // RL20
            `HSR_OFF_SERIAL_HIGH: r = SERIAL_NUMBER[31:16]; // RL20
            default: r = 16'h0000;
        endcase
        return r;
    endfunction

    // Switchover only when every Ethernet port has lost link.
    assign allLinksLost = ~|ethLink; // RL11
    // The partner must be a working standby for a swap to be honoured.
    assign standbyReady = peerValid && (peerState == 4'(HSR_STANDBY)) && peerLinkUp; // RL4 RL17
    assign swapWrite = regReq.wrEn && (regReq.addr == `HSR_OFF_ROLE_SWAP)
                       && (regReq.wrData == `HSR_ROLE_SWAP_KEY); // RL15

    // ==================================================================
    // Next-state logic
    // ==================================================================
    // Transitions are one per cycle; the restart count models the slow
    // token-network restart, so the takeover cannot be made bumpless.
    always_comb
    begin
        next_cur = cur;
        next_cur.commit = 1'b0;
        next_cur.closeProg = 1'b0;
        next_cur.reboot = 1'b0;
        next_cur.rdValid = regReq.rdEn;
        next_cur.rdData = regReq.rdEn ? readReg(regReq.addr, cur.st, peerValid, peerState)
                                      : cur.rdData;
        // Counter published once per second.
        if (cur.secCnt >= SECOND_CYC - 1)
        begin
            next_cur.secCnt = 32'h0000_0000;
            next_cur.aliveCnt = cur.aliveCnt + 16'h0001; // RL21
        end
        else
        begin
            next_cur.secCnt = cur.secCnt + 32'h0000_0001;
        end
        if (swapWrite && cur.st == HSR_LEADER && standbyReady) // RL16 RL17
        begin
            next_cur.swapPending = 1'b1;
        end
        unique case (cur.st)
            HSR_STARTUP:
            begin
                next_cur.st = HSR_INIT_WAIT;
            end
            HSR_INIT_WAIT:
            begin
                if (initLeaderCmd) // RL22
                begin
                    next_cur.pairMode = 1'b1;
                    next_cur.st = HSR_LEADER;
                end
                else if (initStandbyCmd)
                begin
                    next_cur.pairMode = 1'b1;
                    next_cur.st = HSR_RX_CONFIG;
                end
            end
            HSR_LEADER:
            begin
                // Any switch reason, or an older peer firmware, hands over.
                if (soleStation || allLinksLost || firmwareUpdateDone // RL10 RL11 RL13
                    || peerFirmwareOlder || cur.swapPending) // RL14 RL16
                begin
                    next_cur.swapPending = 1'b0;
                    next_cur.st = HSR_TO_STANDBY;
                end
                else if (commitRequest && !(peerValid && peerState == 4'(HSR_RX_CONFIG)))
                begin
                    next_cur.commit = 1'b1; // RL6
                end
            end
            HSR_TO_STANDBY:
            begin
                next_cur.st = soleStation ? HSR_STANDBY_SOLE : HSR_STANDBY;
            end
            HSR_STANDBY, HSR_STANDBY_SOLE:
            begin
                if (peerConfigDiffers) // RL3
                begin
                    next_cur.st = HSR_RX_CONFIG;
                end
                else if ((!peerBcastSeen && !peerLinkUp) || peerFirmwareNewer // RL12 RL14
                         || (peerValid && peerState == 4'(HSR_TO_STANDBY))) // RL1
                begin
                    next_cur.restartCnt = 32'h0000_0000;
                    next_cur.closeProg = 1'b1; // RL8
                    next_cur.st = HSR_TO_LEADER;
                end
                else
                begin
                    next_cur.st = soleStation ? HSR_STANDBY_SOLE : HSR_STANDBY;
                end
            end
            HSR_TO_LEADER:
            begin
                if (cur.restartCnt >= RESTART_CYC - 1) // RL7
                begin
                    next_cur.st = HSR_LEADER;
                end
                else
                begin
                    next_cur.restartCnt = cur.restartCnt + 32'h0000_0001;
                end
            end
            HSR_RX_CONFIG:
            begin
                if (fetchDone) // RL23
                begin
                    next_cur.reboot = 1'b1;
                    next_cur.st = HSR_STARTUP;
                end
            end
            HSR_OFFLINE, HSR_HOLD_OFFLINE, HSR_HOLD_SOLE:
            begin
                next_cur.st = HSR_INIT_WAIT;
            end
            default:
            begin
                next_cur.st = HSR_STARTUP;
            end
        endcase
        // Reboot into paired operation keeps the redundant mode set.
        if (cur.st == HSR_STARTUP && cur.pairMode)
        begin
            next_cur.st = HSR_STANDBY;
        end
    end

    // ==================================================================
    // State register
    // ==================================================================
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // ==================================================================
    // Registered outputs
    // ==================================================================
    // Outputs are registered from the next record so they track the state
    // in the same cycle that the state register does.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            bcastWords <= '0;
            regRdData <= 16'h0000;
            regRdValid <= 1'b0;
            redundantPairMode <= 1'b0;
            configWritable <= 1'b0;
            firmwareUpdateAllowed <= 1'b0;
            fetchConfig <= 1'b0;
            commitConfiguration <= 1'b0;
            closeProgramming <= 1'b0;
            rebootRequest <= 1'b0;
            ipAddress <= 32'h0000_0000;
            nodeNumber <= 8'h00;
            mailboxBcastAllowed <= 1'b1;
        end
        else
        begin
            bcastWords.word0 <= next_cur.aliveCnt; // RL21
            bcastWords.word1 <= {12'h000, next_cur.st}; // RL24
            bcastWords.word2 <= peerValid ? {12'h000, peerState} : `HSR_PEER_UNKNOWN; // RL24
            bcastWords.word3 <= SERIAL_NUMBER[15:0];
            bcastWords.word4 <= SERIAL_NUMBER[31:16];
            regRdData <= next_cur.rdData;
            regRdValid <= next_cur.rdValid;
            redundantPairMode <= next_cur.pairMode;
            configWritable <= !next_cur.pairMode || next_cur.st == HSR_LEADER; // RL2
            firmwareUpdateAllowed <= !next_cur.pairMode || next_cur.st == HSR_LEADER; // RL14
            fetchConfig <= next_cur.st == HSR_RX_CONFIG; // RL3
            commitConfiguration <= next_cur.commit;
            closeProgramming <= next_cur.closeProg;
            rebootRequest <= next_cur.reboot;
            mailboxBcastAllowed <= !next_cur.pairMode; // RL9
            // Leader uses the base identity, standby the base plus one.
            if (next_cur.st == HSR_LEADER || !next_cur.pairMode) // RL1
            begin
                ipAddress <= ipBase;
                nodeNumber <= nodeBase;
            end
            else
            begin
                ipAddress <= ipBase + 32'h0000_0001; // RL5
                nodeNumber <= nodeBase + 8'h01; // RL5
            end
        end
    end

    // ==================================================================
    // Checks
    // ==================================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    own_state_read_a: assert property (regReq.rdEn && regReq.addr == `HSR_OFF_OWN_STATE
        |=> regRdValid && regRdData == {12'h000, $past(cur.st)}) // RL18
        else $error("own state read wrong");
    peer_unknown_a: assert property (regReq.rdEn && regReq.addr == `HSR_OFF_PEER_STATE
        && !peerValid |=> regRdData == `HSR_PEER_UNKNOWN) // RL19
        else $error("peer unknown not reported");
    serial_high_a: assert property (regReq.rdEn && regReq.addr == `HSR_OFF_SERIAL_HIGH
        |=> regRdData == SERIAL_NUMBER[31:16]) // RL20
        else $error("serial high word wrong");
    write_lock_a: assert property (configWritable && redundantPairMode
        |-> cur.st == HSR_LEADER) // RL2
        else $error("standby config writable");
    standby_ident_a: assert property (redundantPairMode && cur.st == HSR_STANDBY
        |-> nodeNumber == nodeBase + 8'h01 || $changed(nodeBase)) // RL5
        else $error("standby node not leader plus one");
    sole_switch_a: assert property (cur.st == HSR_LEADER && soleStation
        |=> cur.st == HSR_TO_STANDBY) // RL10
        else $error("sole station not handled");
    commit_block_a: assert property (commitConfiguration
        |-> $past(!(peerValid && peerState == 4'(HSR_RX_CONFIG)))) // RL6
        else $error("commit during fetch");
    swap_ignore_a: assert property (cur.st == HSR_LEADER && swapWrite && !standbyReady
        && !cur.swapPending |=> !cur.swapPending) // RL17
        else $error("swap accepted without ready standby");
    take_close_a: assert property (cur.st != HSR_TO_LEADER ##1 cur.st == HSR_TO_LEADER
        |-> closeProgramming) // RL8
        else $error("programming not closed at takeover");
    bcast_state_a: assert property (##1 bcastWords.word1 == {12'h000, cur.st}) // RL24
        else $error("broadcast state stale");

    swap_cover_c: cover property (cur.st == HSR_LEADER && cur.swapPending ##1
        cur.st == HSR_TO_STANDBY);
    take_cover_c: cover property (cur.st == HSR_TO_LEADER ##1 cur.st == HSR_LEADER);
    fetch_cover_c: cover property (cur.st == HSR_RX_CONFIG ##1 rebootRequest);
endmodule

// *** logic/hsr_defines.svh ***
// Purpose: Constants for the hot-standby redundancy controller.
// Assumes: 100 MHz clock, 16-bit register words.
// Notes: Offsets are register numbers of the device's holding-register space.
`ifndef HSR_DEFINES_SVH
`define HSR_DEFINES_SVH
`define HSR_OFF_OWN_STATE 16'h0855
`define HSR_OFF_PEER_STATE 16'h0856
`define HSR_OFF_SERIAL_LOW 16'h0859
`define HSR_OFF_SERIAL_HIGH 16'h085A
`define HSR_OFF_ROLE_SWAP 16'h1F9C
`define HSR_ROLE_SWAP_KEY 16'hAB00
`define HSR_PEER_UNKNOWN 16'h00FF
`define HSR_CLK_HZ 100000000
`define HSR_RESTART_S 16
`define HSR_RESTART_CYC (`HSR_RESTART_S * `HSR_CLK_HZ)
`define HSR_SECOND_CYC (`HSR_CLK_HZ)
`endif

// *** logic/hsr_pkg.sv ***
// Purpose: Types for the hot-standby redundancy controller.
// Assumes: State codes are the published 0 to 10 values.
// Notes: Constants live in hsr_defines.svh.
package hsr_pkg;
    typedef enum logic [3:0] {
        HSR_STARTUP, HSR_LEADER, HSR_STANDBY, HSR_TO_STANDBY, HSR_TO_LEADER,
        HSR_OFFLINE, HSR_INIT_WAIT, HSR_RX_CONFIG, HSR_STANDBY_SOLE,
        HSR_HOLD_OFFLINE, HSR_HOLD_SOLE
    } hsr_state_t;
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [15:0] addr;
        logic [15:0] wrData;
    } hsr_reg_req_t;
    typedef struct packed {
        logic [15:0] word0;
        logic [15:0] word1;
        logic [15:0] word2;
        logic [15:0] word3;
        logic [15:0] word4;
    } hsr_bcast_t;
endpackage

// *** bench/hsr_peer_model.sv ***
// Purpose: Behavioural model of the partner unit across the peer link.
// Assumes: Bench sets the partner's liveness and state code.
// Notes: A released peer no longer shows its last state.
`timescale 1ns/1ps
module hsr_peer_model #(
    parameter int FETCH_CYC = 6
) (
    input wire logic clk,
    input wire logic alive,
    input wire logic [3:0] stateCode,
    input wire logic cfgDiff,
    input wire logic fetchConfig,
    input wire logic [1:0] fwAge,
    output logic peerBcastSeen,
    output logic peerLinkUp,
    output logic peerValid,
    output logic [3:0] peerState,
    output logic peerConfigDiffers,
    output logic fetchDone,
    output logic peerFirmwareNewer,
    output logic peerFirmwareOlder
);
    int cnt = 0;
    logic diffDone = 1'b0;
    // ==========================================
    // Link and state view
    // Full-duplex link is up only while the partner runs; a dead peer shows junk state.
    assign peerLinkUp = alive;
    assign peerBcastSeen = alive;
    assign peerValid = alive;
    assign peerState = alive ? stateCode : ~stateCode;
    assign peerConfigDiffers = alive && cfgDiff && !diffDone;
    // Bit 1 marks newer partner firmware, bit 0 older partner firmware.
    assign peerFirmwareNewer = alive && fwAge[1];
    assign peerFirmwareOlder = alive && fwAge[0];
    // Serve a whole configuration fetch after a slow transfer.
    initial fetchDone = 1'b0;
    always @(posedge clk)
    begin
        fetchDone <= 1'b0;
        if (!cfgDiff)
            diffDone <= 1'b0;
        if (fetchConfig === 1'b1 && alive)
        begin
            cnt++;
            if (cnt == FETCH_CYC)
            begin
                fetchDone <= 1'b1;
                diffDone <= 1'b1;
                cnt = 0;
            end
        end
        else
        begin
            // A fresh fetch always starts its count from zero.
            cnt = 0;
        end
    end
endmodule

// *** bench/hot_standby_redundancy_ctrl_test.sv ***
// Purpose: Self-checking bench for the redundancy controller.
// Assumes: Restart and second counts shortened through parameters.
// Notes: Own state is watched on broadcast word 1.
`timescale 1ns/1ps
module hot_standby_redundancy_ctrl_test;
    import hsr_pkg::*;
    localparam logic [31:0] SN = 32'h000C_35B7; // Arbitrary value.
    localparam logic [31:0] IPB = 32'hC0A8_05B2;
    logic clk = 0, sys_rst = 1;
    hsr_reg_req_t regReq = '0;
    hsr_bcast_t bcastWords;
    logic [15:0] regRdData;
    logic regRdValid, initLeaderCmd = 0, initStandbyCmd = 0, soleStation = 0;
    logic [1:0] ethLink = 2'h3;
    logic peerBcastSeen, peerLinkUp, peerValid, peerConfigDiffers, fetchDone;
    logic peerFirmwareNewer, peerFirmwareOlder, commitRequest = 0;
    logic [3:0] peerState, peerCode = 4'h5;
    logic alive = 0, cfgDiff = 0, fwDone = 0;
    logic [1:0] fwAge = 2'b00;
    logic [7:0] nodeB = 8'h35;
    logic redundantPairMode, configWritable, firmwareUpdateAllowed, fetchConfig;
    logic commitConfiguration, closeProgramming, rebootRequest, mailboxBcastAllowed;
    logic [31:0] ipAddress;
    logic [7:0] nodeNumber;
    int badCount = 0, samplesChecked = 0, nCommit = 0, nClose = 0, nBoot = 0, c0;
    logic [15:0] w0;
    hsr_ctrl #(.RESTART_CYC(20), .SECOND_CYC(10), .SERIAL_NUMBER(SN), .ETH_PORTS(2)) i_hsr_ctrl (
        .clk(clk), .sys_rst(sys_rst), .regReq(regReq), .bcastWords(bcastWords),
        .regRdData(regRdData), .regRdValid(regRdValid), .initLeaderCmd(initLeaderCmd),
        .initStandbyCmd(initStandbyCmd), .soleStation(soleStation), .ethLink(ethLink),
        .peerBcastSeen(peerBcastSeen), .peerLinkUp(peerLinkUp), .peerValid(peerValid),
        .peerState(peerState), .peerConfigDiffers(peerConfigDiffers), .fetchDone(fetchDone),
        .firmwareUpdateDone(fwDone), .peerFirmwareNewer(peerFirmwareNewer),
        .peerFirmwareOlder(peerFirmwareOlder), .commitRequest(commitRequest), .ipBase(IPB),
        .nodeBase(nodeB), .redundantPairMode(redundantPairMode),
        .configWritable(configWritable), .firmwareUpdateAllowed(firmwareUpdateAllowed),
        .fetchConfig(fetchConfig), .commitConfiguration(commitConfiguration),
        .closeProgramming(closeProgramming), .rebootRequest(rebootRequest),
        .ipAddress(ipAddress), .nodeNumber(nodeNumber), .mailboxBcastAllowed(mailboxBcastAllowed));
    hsr_peer_model #(.FETCH_CYC(6)) i_hsr_peer_model (
        .clk(clk), .alive(alive), .stateCode(peerCode), .cfgDiff(cfgDiff), .fwAge(fwAge),
        .fetchConfig(fetchConfig), .peerBcastSeen(peerBcastSeen), .peerLinkUp(peerLinkUp),
        .peerValid(peerValid), .peerState(peerState), .peerConfigDiffers(peerConfigDiffers),
        .fetchDone(fetchDone), .peerFirmwareNewer(peerFirmwareNewer),
        .peerFirmwareOlder(peerFirmwareOlder));
    // ==========================================
    // Clock and pulse counters
    initial forever #5 clk = ~clk;
    // Pulses are counted in the background so that no one-cycle event is missed.
    always @(posedge clk)
    begin
        nCommit += (commitConfiguration === 1'b1);
        nClose += (closeProgramming === 1'b1);
        nBoot += (rebootRequest === 1'b1);
    end
    task automatic summarize;
        $display("checks %0d mismatches %0d", samplesChecked, badCount);
        if (badCount == 0 && samplesChecked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp)
        begin
            badCount++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // Bounded wait for a state code; a hang shows up as a mismatch.
    task automatic waitState(input logic [15:0] code, input int lim);
        for (int n = 0; n < lim && bcastWords.word1 !== code; n++) @(negedge clk);
        chk("own state", bcastWords.word1, code);
    endtask
    task automatic regRead(input logic [15:0] a, input logic [15:0] exp);
        @(negedge clk);
        regReq.rdEn = 1;
        regReq.addr = a;
        @(negedge clk);
        regReq.rdEn = 0;
        for (int i = 0; i < 2 && regRdValid !== 1'b1; i++) @(negedge clk);
        chk("read valid", regRdValid, 1);
        chk("read data", regRdData, exp);
    endtask
    task automatic regWrite(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk);
        regReq.wrEn = 1;
        regReq.addr = a;
        regReq.wrData = d;
        @(negedge clk);
        regReq.wrEn = 0;
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1;
        @(negedge clk);
        s = 0;
    endtask
    task automatic commitTry(input int exp);
        c0 = nCommit;
        pulse(commitRequest);
        repeat (3) @(negedge clk);
        chk("commit pulses", nCommit - c0, exp);
    endtask
    // ==========================================
    // Watchdog
    initial
    begin
        repeat (5000) @(posedge clk);
        badCount++;
        summarize();
    end
    // ==========================================
    // Main sequence
    initial
    begin
        repeat (12) @(negedge clk);
        sys_rst = 0;
        chk("mailbox", mailboxBcastAllowed, 1);
        waitState(16'h6, 4);
        regRead(16'h0855, 16'h6);
        regRead(16'h0856, 16'h00FF);
        regRead(16'h0859, SN[15:0]);
        regRead(16'h085A, SN[31:16]);
        regRead(16'h0000, 16'h0);
        $display("test reset and registers done");
        pulse(initLeaderCmd);
        waitState(16'h1, 5);
        chk("pair mode", redundantPairMode, 1);
        chk("mailbox", mailboxBcastAllowed, 0);
        chk("writable", configWritable, 1);
        chk("firmware", firmwareUpdateAllowed, 1);
        chk("ip", ipAddress, IPB);
        chk("serial words", {bcastWords.word4, bcastWords.word3}, SN);
        w0 = bcastWords.word0;
        repeat (10) @(negedge clk);
        chk("seconds", bcastWords.word0, w0 + 16'h1);
        $display("test leader init done");
        alive = 1;
        regWrite(16'h1F9C, 16'hAB00);
        repeat (5) @(negedge clk);
        chk("swap refused", bcastWords.word1, 1);
        peerCode = 4'h2;
        regWrite(16'h1F9C, 16'hAB01);
        repeat (5) @(negedge clk);
        chk("wrong key", bcastWords.word1, 1);
        commitTry(1);
        peerCode = 4'h7;
        commitTry(0);
        peerCode = 4'h2;
        $display("test refusals done");
        regWrite(16'h1F9C, 16'hAB00);
        peerCode = 4'h1;
        waitState(16'h3, 4);
        waitState(16'h2, 6);
        chk("writable", configWritable, 0);
        chk("firmware", firmwareUpdateAllowed, 0);
        chk("ip", ipAddress, IPB + 1);
        chk("node", nodeNumber, 8'h36);
        regRead(16'h0856, 16'h1);
        chk("peer word", bcastWords.word2, 1);
        $display("test role swap done");
        c0 = nBoot;
        cfgDiff = 1;
        waitState(16'h7, 4);
        chk("fetch", fetchConfig, 1);
        waitState(16'h2, 30);
        chk("reboots", nBoot - c0, 1);
        cfgDiff = 0;
        $display("test config fetch done");
        c0 = nClose;
        alive = 0;
        waitState(16'h4, 4);
        repeat (10) @(negedge clk);
        chk("restart", bcastWords.word1, 4);
        waitState(16'h1, 20);
        chk("closes", nClose - c0, 1);
        chk("ip", ipAddress, IPB);
        chk("node", nodeNumber, 8'h35);
        $display("test takeover done");
        alive = 1;
        peerCode = 4'h2;
        ethLink = 2'h1;
        repeat (5) @(negedge clk);
        chk("one link", bcastWords.word1, 1);
        ethLink = 2'h0;
        waitState(16'h3, 5);
        $display("test link loss done");
        ethLink = 2'h3;
        fwAge = 2'b10;
        waitState(16'h4, 4);
        fwAge = 2'b00;
        waitState(16'h1, 30);
        pulse(fwDone);
        waitState(16'h3, 4);
        waitState(16'h2, 4);
        peerCode = 4'h3;
        waitState(16'h1, 30);
        peerCode = 4'h2;
        fwAge = 2'b01;
        waitState(16'h3, 4);
        fwAge = 2'b00;
        peerCode = 4'h3;
        waitState(16'h1, 30);
        peerCode = 4'h2;
        soleStation = 1;
        waitState(16'h3, 4);
        waitState(16'h8, 4);
        $display("test firmware and sole station done");
        summarize();
    end
endmodule
